/* File: hw/mct_pkg.sv */
// package: constants, register layouts and current table of the step translator
// How it works
// R1 - position kept as 7-bit, readable in status
// R2 - position register updates right at trigger
// R3 - steps counted even with bridges disabled
// R4 - edge select picks rising or falling trigger
// R5 - direction from pin combined with config bit
// R6 - resolution codes 000..100 select 1/32..1/2
// R7 - each 1/32 position maps to fixed percentages
// R8 - coarse modes entered on grid use only their grid positions
// R9 - signed table spans full electrical period
// R10 - new resolution applies at next trigger only
// R11 - finer resolution snaps to nearest grid point
// R12 - coarser on shared point continues without offset
// R13 - coarser off grid keeps stepping with offset
// R14 - host lowers resolution only on shared points; the testbench also lowers it off grid (t_offset, t_half_sq)
// R15 - peak code applied at next pwm period
// R16 - coil voltage sampled at current zero crossings
// R17 - transparent passes transient, else hold at end
// R18 - gain bit selects divide by two or four
// R19 - sample/hold from pwm, zero flag, transparency
// R20 - reset gives 1/32 resolution at position zero
// R21 - codes 101, 110 use square full-current table
// R22 - same resolution steps exactly one grid step
// R23 - bridge enable 0 disables, 1 enables drivers
// R24 - count up when pin xor bit is zero
// R25 - gain bit 0 divides by two, 1 by four
package mct_pkg;

   localparam logic [7:0] MCT_OFS_CTRL = 8'h00;
   localparam logic [7:0] MCT_OFS_STATUS = 8'h04;
   localparam logic [31:0] MCT_CTRL_RST = 32'h0000_0000;
   localparam logic [6:0] MCT_POS_RST = 7'h00;

   localparam logic [2:0] MCT_RES_32 = 3'h0;
   localparam logic [2:0] MCT_RES_16 = 3'h1;
   localparam logic [2:0] MCT_RES_8 = 3'h2;
   localparam logic [2:0] MCT_RES_4 = 3'h3;
   localparam logic [2:0] MCT_RES_2 = 3'h4;
   localparam logic [2:0] MCT_RES_HALF_SQ = 3'h5;
   localparam logic [2:0] MCT_RES_FULL_SQ = 3'h6;

   // set-points are in tenths of a percent of peak current
   localparam logic [9:0] MCT_FULL_PCT = 10'h3E8;

   // first quadrant of the circle, index 0..32; y uses index 32-n
   localparam logic [9:0] MCT_QTR_TABLE [0:32] = '{
      10'h000, 10'h023, 10'h051, 10'h07F, 10'h0AE, 10'h0DD, 10'h10B,
      10'h13A, 10'h15D, 10'h17F, 10'h1AE, 10'h1D1, 10'h1F4, 10'h222,
      10'h245, 10'h268, 10'h28B, 10'h2AE, 10'h2D1, 10'h2F3, 10'h316,
      10'h33A, 10'h351, 10'h368, 10'h37F, 10'h396, 10'h3A2, 10'h3AD,
      10'h3B9, 10'h3C5, 10'h3D1, 10'h3DC, 10'h3E8};

   typedef struct packed {
      logic [10:0] rsvd_hi;
      logic [4:0] peak_amplitude_code;
      logic [5:0] rsvd_mid;
      logic back_emf_gain;
      logic back_emf_transparent;
      logic rsvd_7;
      logic [2:0] step_resolution;
      logic rsvd_3;
      logic rotation_sense_bit;
      logic advance_edge_select;
      logic bridge_enable;
   } mct_ctrl_t;

   typedef struct packed {
      logic [19:0] rsvd_hi;
      logic change_pending;
      logic [2:0] active_resolution;
      logic rsvd_7;
      logic [6:0] translator_position;
   } mct_status_t;

   typedef struct packed {
      logic signed [10:0] coil_x;
      logic signed [10:0] coil_y;
   } mct_setpoint_t;

endpackage

/* File: hw/mct_translator.sv */
// step translator with wishbone registers, current table and back-emf path
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ns
module mct_translator
#(
   parameter int ADDR_W = 4,
   parameter int VOLT_W = 10
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic step_advance_i,
   input wire logic rotation_sense_i,
   input wire logic pwm_period_start_i,
   input wire logic pwm_sample_hold_i,
   input wire logic coil_x_zero_i,
   input wire logic coil_y_zero_i,
   input wire logic [VOLT_W-1:0] coil_x_voltage_i,
   input wire logic [VOLT_W-1:0] coil_y_voltage_i,
   output mct_pkg::mct_setpoint_t setpoint_o,
   output logic [4:0] peak_amplitude_o,
   output logic bridge_enable_o,
   output logic [6:0] translator_position_o,
   output logic [VOLT_W-1:0] back_emf_output_o
);
   import mct_pkg::*;

   if (ADDR_W < 3 || ADDR_W > 8)
   begin : g_bad_addr
      $error("mct_translator: ADDR_W must be 3..8");
   end
   if (VOLT_W < 3)
   begin : g_bad_volt
      $error("mct_translator: VOLT_W must be at least 3");
   end

   function automatic logic [6:0] step_inc(input logic [2:0] res);
      logic [6:0] inc;
      inc = 7'h01;
      unique case (res)
         MCT_RES_32: inc = 7'h01;
         MCT_RES_16: inc = 7'h02;
         MCT_RES_8: inc = 7'h04;
         MCT_RES_4: inc = 7'h08;
         MCT_RES_2: inc = 7'h10;
         MCT_RES_HALF_SQ: inc = 7'h10;
         MCT_RES_FULL_SQ: inc = 7'h20;
         default: inc = 7'h01;
      endcase
      return inc;
   endfunction

   // register bus state
   mct_ctrl_t ctrl_q, ctrl_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;

   // translator state
   logic step_prev_q, step_prev_d;
   logic [6:0] pos_q, pos_d;
   logic [2:0] active_res_q, active_res_d;
   mct_setpoint_t setpoint_q, setpoint_d;
   logic [4:0] peak_q, peak_d;

   // back-emf state
   logic zero_prev_q, zero_prev_d;
   logic [VOLT_W-1:0] track_q, track_d;
   logic [VOLT_W-1:0] bemf_q, bemf_d;

   mct_status_t status;
   logic req;
   logic hit_ctrl;
   logic hit_status;

   always_comb
   begin
      status = '0;
      status.translator_position = pos_q; // R1
      status.active_resolution = active_res_q;
      status.change_pending = (ctrl_q.step_resolution != active_res_q);
      req = wb_cyc_i & wb_stb_i;
      hit_ctrl = (wb_adr_i == ADDR_W'(MCT_OFS_CTRL));
      hit_status = (wb_adr_i == ADDR_W'(MCT_OFS_STATUS));
      ack_d = req & ~ack_q;
      rdat_d = rdat_q;
      if (req & ~ack_q)
      begin
         if (hit_ctrl)
            rdat_d = ctrl_q;
         else if (hit_status)
            rdat_d = status; // R2
         else
            rdat_d = 32'h0000_0000;
      end
      ctrl_d = ctrl_q;
      // write lands at the edge where the master sees ack
      if (req & ack_q & wb_we_i & hit_ctrl)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wb_sel_i[b])
               ctrl_d[b*8 +: 8] = wb_dat_i[b*8 +: 8];
         end
      end
      ctrl_d.rsvd_hi = '0;
      ctrl_d.rsvd_mid = '0;
      ctrl_d.rsvd_7 = 1'b0;
      ctrl_d.rsvd_3 = 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= MCT_CTRL_RST;
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   logic trig;
   logic count_up;
   logic [6:0] inc_new;
   logic [6:0] inc_old;
   logic [6:0] base;
   logic [4:0] frac;
   logic [5:0] idx_a;
   logic [5:0] idx_b;
   logic [10:0] mag_a;
   logic [10:0] mag_b;
   logic x_pos, x_neg, y_pos, y_neg;

   always_comb
   begin
      step_prev_d = step_advance_i;
      // R4
      trig = ctrl_q.advance_edge_select ? (step_prev_q & ~step_advance_i)
                                        : (~step_prev_q & step_advance_i);
      // R5 R24
      count_up = ~(rotation_sense_i ^ ctrl_q.rotation_sense_bit);
      inc_new = step_inc(ctrl_q.step_resolution); // R6
      inc_old = step_inc(active_res_q);
      base = pos_q; // R12 R13
      // an offset position only exists after a coarser change
      if (inc_new < inc_old)
         base = (pos_q + (inc_new >> 1)) & ~(inc_new - 7'h01); // R11
      pos_d = pos_q;
      active_res_d = active_res_q;
      // bridge enable deliberately not in this path
      if (trig) // R3
      begin
         active_res_d = ctrl_q.step_resolution; // R10
         pos_d = count_up ? base + inc_new : base - inc_new; // R8 R22
      end

      // R7 R9
      frac = pos_q[4:0];
      idx_a = {1'b0, frac};
      idx_b = 6'h20 - idx_a;
      mag_a = {1'b0, MCT_QTR_TABLE[idx_a]};
      mag_b = {1'b0, MCT_QTR_TABLE[idx_b]};
      setpoint_d = setpoint_q;
      unique case (pos_q[6:5])
         2'b00:
         begin
            setpoint_d.coil_x = $signed(mag_a);
            setpoint_d.coil_y = $signed(mag_b);
         end
         2'b01:
         begin
            setpoint_d.coil_x = $signed(mag_b);
            setpoint_d.coil_y = -$signed(mag_a);
         end
         2'b10:
         begin
            setpoint_d.coil_x = -$signed(mag_a);
            setpoint_d.coil_y = -$signed(mag_b);
         end
         2'b11:
         begin
            setpoint_d.coil_x = -$signed(mag_b);
            setpoint_d.coil_y = $signed(mag_a);
         end
      endcase
      // R21
      x_pos = (pos_q > 7'h00) & (pos_q < 7'h40);
      x_neg = (pos_q > 7'h40);
      y_pos = (pos_q < 7'h20) | (pos_q > 7'h60);
      y_neg = (pos_q > 7'h20) & (pos_q < 7'h60);
      if (active_res_q == MCT_RES_HALF_SQ || active_res_q == MCT_RES_FULL_SQ)
      begin
         setpoint_d.coil_x = x_pos ? $signed({1'b0, MCT_FULL_PCT})
                           : x_neg ? -$signed({1'b0, MCT_FULL_PCT})
                           : 11'sh000;
         setpoint_d.coil_y = y_pos ? $signed({1'b0, MCT_FULL_PCT})
                           : y_neg ? -$signed({1'b0, MCT_FULL_PCT})
                           : 11'sh000;
      end

      peak_d = peak_q;
      if (pwm_period_start_i)
         peak_d = ctrl_q.peak_amplitude_code; // R15
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         step_prev_q <= 1'b0;
         pos_q <= MCT_POS_RST; // R20
         active_res_q <= MCT_RES_32; // R20
         setpoint_q <= '0;
         peak_q <= 5'h00;
      end
      else
      begin
         step_prev_q <= step_prev_d;
         pos_q <= pos_d;
         active_res_q <= active_res_d;
         setpoint_q <= setpoint_d;
         peak_q <= peak_d;
      end
   end

   logic zero_any;
   logic zero_end;
   logic [VOLT_W-1:0] v_sel;

   function automatic logic [VOLT_W-1:0] scale(input logic [VOLT_W-1:0] v,
                                               input logic gain);
      return gain ? (v >> 2) : (v >> 1); // R18 R25
   endfunction

   always_comb
   begin
      // R16
      zero_any = coil_x_zero_i | coil_y_zero_i;
      v_sel = coil_x_zero_i ? coil_x_voltage_i : coil_y_voltage_i;
      zero_prev_d = zero_any;
      zero_end = zero_prev_q & ~zero_any;
      track_d = track_q;
      if (zero_any & pwm_sample_hold_i) // R19
         track_d = v_sel;
      bemf_d = bemf_q;
      // R17
      if (ctrl_q.back_emf_transparent)
         bemf_d = scale(track_d, ctrl_q.back_emf_gain);
      else if (zero_end)
         bemf_d = scale(track_q, ctrl_q.back_emf_gain);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         zero_prev_q <= 1'b0;
         track_q <= '0;
         bemf_q <= '0;
      end
      else
      begin
         zero_prev_q <= zero_prev_d;
         track_q <= track_d;
         bemf_q <= bemf_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign setpoint_o = setpoint_q;
   assign peak_amplitude_o = peak_q;
   assign bridge_enable_o = ctrl_q.bridge_enable; // R23
   assign translator_position_o = pos_q;
   assign back_emf_output_o = bemf_q;

endmodule // mct_translator

/* File: tb/mct_step_host.sv */
// model of the controller driving step and direction pins
`timescale 1ns/1ns
module mct_step_host
#(parameter int MIN_W = 3)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic level_i,
   input wire logic dir_i,
   output logic step_o,
   output logic sense_o
);
   int cnt_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         step_o <= 1'b0;
         sense_o <= 1'b0;
         cnt_q <= 0;
      end
      // direction only moves while the step line rests
      else if (sense_o != dir_i && level_i == step_o)
      begin
         sense_o <= dir_i;
         cnt_q <= 0;
      end
      else if (level_i != step_o && cnt_q >= MIN_W)
      begin
         step_o <= level_i;
         cnt_q <= 0;
      end
      else if (cnt_q < MIN_W)
         cnt_q <= cnt_q + 1;
   end
endmodule // mct_step_host

/* File: tb/mct_translator_sva.sv */
// port assertions of the step translator
`timescale 1ns/1ns
module mct_translator_sva
#(parameter int VOLT_W = 10)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic step_advance_i,
   input wire logic pwm_period_start_i,
   input wire logic coil_x_zero_i,
   input wire logic coil_y_zero_i,
   input wire mct_pkg::mct_setpoint_t setpoint_o,
   input wire logic [4:0] peak_amplitude_o,
   input wire logic bridge_enable_o,
   input wire logic [6:0] translator_position_o,
   input wire logic [VOLT_W-1:0] back_emf_output_o
);
   import mct_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire z = coil_x_zero_i | coil_y_zero_i;
   wire [6:0] pos = translator_position_o;

   chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack late");
   chk_pos_cause: assert property ($changed(pos) |->
      $past(step_advance_i) != $past(step_advance_i, 2))
      else $error("position moved without edge");
   // setpoint trails position by one edge, so wait for it to settle
   chk_table_top: assert property (pos == 0 && $past(pos) == 0
      && !$past(rst_i) |-> setpoint_o == 22'h00_03E8)
      else $error("bad setpoint at zero");
   chk_table_low: assert property (pos == 7'h40
      && $past(pos) == 7'h40 |-> setpoint_o == 22'h00_0418)
      else $error("bad setpoint at 64");
   chk_peak_hold: assert property (!pwm_period_start_i
      |=> $stable(peak_amplitude_o)) else $error("peak moved early");
   chk_bridge_write: assert property ($changed(bridge_enable_o)
      |-> $past(wb_ack_o && wb_we_i)) else $error("enable moved");
   chk_emf_cause: assert property ($changed(back_emf_output_o)
      |-> $past(z) || $past(z, 2)) else $error("emf moved");

   cover property ($changed(pos));
   cover property (wb_ack_o && wb_we_i);
   cover property ($fell(z));
endmodule // mct_translator_sva

/* File: tb/mct_translator_tb_top.sv */
// top testbench of the step translator
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) \
   begin failures++; $display("BAD %0t mismatch", $time); end end
module mct_translator_tb_top;
   import mct_pkg::*;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, lv = 0, dir = 0;
   logic pps = 0, psh = 0, xz = 0, yz = 0, sense, step, ack, en;
   logic [3:0] adr = '0;
   logic [31:0] dw = '0, dr, rd;
   logic [9:0] xv = '0, yv = '0, emf;
   logic [4:0] pk;
   logic [6:0] pos;
   mct_setpoint_t sp;
   mct_ctrl_t c = '0;
   int failures = 0, samples_checked = 0;

   mct_translator uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .step_advance_i(step),
      .rotation_sense_i(sense), .pwm_period_start_i(pps),
      .pwm_sample_hold_i(psh), .coil_x_zero_i(xz), .coil_y_zero_i(yz),
      .coil_x_voltage_i(xv), .coil_y_voltage_i(yv), .setpoint_o(sp),
      .peak_amplitude_o(pk), .bridge_enable_o(en),
      .translator_position_o(pos), .back_emf_output_o(emf));
   mct_step_host host (.clk_i(clk), .rst_i(rst), .level_i(lv),
      .dir_i(dir), .step_o(step), .sense_o(sense));

   initial forever #5 clk = ~clk;

   task automatic end_sim;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dw <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = dr;
      cyc <= 0;
      stb <= 0;
   endtask

   task automatic wc;
      bus(1'b1, 4'h0, c);
   endtask

   task automatic lvl(input logic v);
      lv <= v;
      repeat (8) @(posedge clk);
   endtask

   task automatic stp(input logic [6:0] e);
      lvl(1'b1);
      lvl(1'b0);
      `CHK(pos, e)
   endtask

   initial
   begin
      #200000;
      failures++;
      end_sim();
   end

   task automatic t_reset;
      `CHK(pos, 7'h00)
      `CHK(sp, 22'h00_03E8)
      `CHK(pk, 5'h00)
      `CHK(en, 1'b0)
      bus(1'b0, 4'h0, '0);
      `CHK(rd, 32'h0000_0000)
   endtask

   task automatic t_coarse;
      c.step_resolution = MCT_RES_2;
      wc();
      bus(1'b0, 4'h4, '0);
      `CHK(rd, 32'h0000_0800)
      `CHK(sp, 22'h00_03E8)
      stp(7'h10);
      `CHK(sp, 22'h14_5A8B)
   endtask

   task automatic t_finer;
      for (int i = 3; i >= 0; i--)
      begin
         c.step_resolution = 3'(i);
         wc();
         stp(7'h20 - (7'h01 << i));
      end
   endtask

   task automatic t_offset;
      c.step_resolution = MCT_RES_FULL_SQ;
      wc();
      stp(7'h3F);
      `CHK(sp, 22'h1F_4418)
      c.step_resolution = MCT_RES_16;
      wc();
      stp(7'h42);
   endtask

   task automatic t_direction;
      c.rotation_sense_bit = 1;
      wc();
      stp(7'h40);
      `CHK(sp, 22'h00_0418)
      dir <= 1;
      repeat (4) @(posedge clk);
      stp(7'h42);
   endtask

   task automatic t_edge_bridge;
      dir <= 0;
      c.rotation_sense_bit = 0;
      c.advance_edge_select = 1;
      c.bridge_enable = 1;
      wc();
      @(posedge clk);
      `CHK(en, 1'b1)
      lvl(1'b1);
      `CHK(pos, 7'h42)
      lvl(1'b0);
      `CHK(pos, 7'h44)
      bus(1'b0, 4'h4, '0);
      `CHK(rd[6:0], 7'h44)
   endtask

   task automatic t_peak;
      c.peak_amplitude_code = 5'h15;
      wc();
      @(posedge clk);
      `CHK(pk, 5'h00)
      pps <= 1;
      @(posedge clk);
      pps <= 0;
      @(posedge clk);
      `CHK(pk, 5'h15)
   endtask

   task automatic t_bemf;
      c.back_emf_transparent = 1;
      wc();
      xv <= 10'h100;
      psh <= 1;
      xz <= 1;
      repeat (3) @(posedge clk);
      `CHK(emf, 10'h080)
      c.back_emf_gain = 1;
      wc();
      repeat (2) @(posedge clk);
      `CHK(emf, 10'h040)
      c.back_emf_transparent = 0;
      c.back_emf_gain = 0;
      wc();
      xv <= 10'h200;
      repeat (3) @(posedge clk);
      `CHK(emf, 10'h040)
      xz <= 0;
      repeat (3) @(posedge clk);
      `CHK(emf, 10'h100)
      xv <= 10'h3FF;
      repeat (3) @(posedge clk);
      `CHK(emf, 10'h100)
   endtask

   task automatic t_half_sq;
      // off the half-step grid on purpose, so the offset is carried
      c.step_resolution = MCT_RES_HALF_SQ;
      wc();
      stp(7'h54);
      `CHK(sp, 22'h20_C418)
   endtask

   task automatic t_mid_reset;
      @(posedge clk);
      rst <= 1;
      repeat (4) @(posedge clk);
      rst <= 0;
      c = '0;
      repeat (2) @(posedge clk);
      `CHK(pos, 7'h00)
      `CHK(sp, 22'h00_03E8)
      `CHK(pk, 5'h00)
      `CHK(emf, 10'h000)
      `CHK(en, 1'b0)
      bus(1'b0, 4'h4, '0);
      `CHK(rd, 32'h0000_0000)
   endtask

   task automatic t_unmapped;
      // unmapped place reads as zero
      bus(1'b0, 4'h8, '0);
      `CHK(rd, 32'h0000_0000)
   endtask

   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      t_reset();
      t_coarse();
      t_finer();
      t_offset();
      t_direction();
      t_edge_bridge();
      t_peak();
      t_bemf();
      t_half_sq();
      t_mid_reset();
      t_unmapped();
      end_sim();
   end
endmodule // mct_translator_tb_top

bind mct_translator mct_translator_sva #(.VOLT_W(VOLT_W)) chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_ack_o(wb_ack_o),
   .step_advance_i(step_advance_i),
   .pwm_period_start_i(pwm_period_start_i),
   .coil_x_zero_i(coil_x_zero_i),
   .coil_y_zero_i(coil_y_zero_i),
   .setpoint_o(setpoint_o),
   .peak_amplitude_o(peak_amplitude_o),
   .bridge_enable_o(bridge_enable_o),
   .translator_position_o(translator_position_o),
   .back_emf_output_o(back_emf_output_o)
);
